// ===== logic/status_byte_map.vh
// Bit positions, register selects and reset values of the status block
// Included by the status byte design files
`ifndef STATUS_BYTE_MAP_VH
`define STATUS_BYTE_MAP_VH
`define SB_RQS_BIT        6
`define SB_ESB_BIT        5
`define SB_MAV_BIT        4
`define SB_EAV_BIT        3
`define SB_STATUS_CHANGE_SUMMARY_BIT_BIT       2
`define ES_PON_BIT        7
`define ES_CME_BIT        5
`define ES_EXE_BIT        4
`define ES_DDE_BIT        3
`define ES_QYE_BIT        2
`define ES_OPC_BIT        0
`define SB_USED_MASK      8'h3c
`define ES_USED_MASK      16'h00bd
`define SEL_POLL_BYTE     2'h0
`define SEL_SVC_ENABLE    2'h1
`define SEL_EVENT_STATUS  2'h2
`define SEL_EVENT_ENABLE  2'h3
`define RST_BYTE          8'h00
`define RST_WORD          16'h0000
`define ERR_QUEUE_DEPTH   16
`define ERR_QUEUE_KEEP    15
`define CHAR_CTRL_P       8'h10
`endif

// ===== logic/error_code_queue.v
// Error queue: keeps codes of the first errors, oldest read first
// Assumes push and pop are single-cycle pulses on clk_in
`timescale 1ns/100ps
`include "status_byte_map.vh"
module error_code_queue #(
  parameter CODE_W = 16,
  parameter DEPTH  = `ERR_QUEUE_DEPTH,
  parameter KEEP   = `ERR_QUEUE_KEEP
) (
  input  wire              clk_in,
  input  wire              rst_in,
  input  wire              clear_in,
  input  wire              push_in,
  input  wire [CODE_W-1:0] code_in,
  input  wire              pop_in,
  output reg  [CODE_W-1:0] head_out,
  output reg               nonempty_out
);
  reg [CODE_W-1:0] mem_reg [0:DEPTH-1];
  reg [4:0]        wr_reg;
  reg [4:0]        rd_reg;
  reg [4:0]        cnt_reg;
  wire             do_pop;
  wire             do_push;
  wire [4:0]       cnt_next;

  assign do_pop   = pop_in && (cnt_reg != 5'h00);
  assign do_push  = push_in && (cnt_reg < KEEP[4:0]);
  assign cnt_next = cnt_reg + {4'h0, do_push} - {4'h0, do_pop};

  always @(posedge clk_in) begin
    if (do_push) begin
      mem_reg[wr_reg[3:0]] <= code_in;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      wr_reg       <= 5'h00;
      rd_reg       <= 5'h00;
      cnt_reg      <= 5'h00;
      nonempty_out <= 1'b0;
      head_out     <= {CODE_W{1'b0}};
    end else begin
      if (do_push) begin
        wr_reg <= (wr_reg == DEPTH[4:0] - 5'h01) ? 5'h00 : wr_reg + 5'h01;
      end
      if (do_pop) begin
        rd_reg   <= (rd_reg == DEPTH[4:0] - 5'h01) ? 5'h00 : rd_reg + 5'h01;
        head_out <= mem_reg[rd_reg[3:0]];
      end
      cnt_reg      <= cnt_next;
      nonempty_out <= (cnt_next != 5'h00);
    end
  end
endmodule // error_code_queue

// ===== logic/status_byte_service_request.v
// Status byte, event status and service request logic of the remote interface
// Assumes command decode sits outside and gives one-cycle pulses on clk_in
`timescale 1ns/100ps
`include "status_byte_map.vh"
module status_byte_service_request #(
  parameter CODE_W = 16
) (
  input  wire              clk_in,
  input  wire              rst_in,
  input  wire              serial_mode_in,
  input  wire              serial_poll_in,
  input  wire              clear_status_in,
  input  wire              device_clear_in,
  input  wire              reset_cmd_in,
  input  wire              power_cycled_in,
  input  wire              out_buffer_busy_in,
  input  wire              change_summary_in,
  input  wire              command_error_in,
  input  wire              execution_error_in,
  input  wire              device_error_in,
  input  wire              query_error_in,
  input  wire              op_complete_in,
  input  wire [CODE_W-1:0] error_code_in,
  input  wire              error_push_in,
  input  wire              error_pop_in,
  input  wire              rx_char_valid_in,
  input  wire [7:0]        rx_char_in,
  input  wire              reg_write_in,
  input  wire              reg_read_in,
  input  wire [1:0]        reg_sel_in,
  input  wire [15:0]       reg_wdata_in,
  output reg  [15:0]       reg_rdata_out,
  output reg               reg_rvalid_out,
  output reg  [7:0]        poll_byte_out,
  output reg               poll_valid_out,
  output reg               srq_out,
  output reg               srq_string_start_out,
  output reg               poll_string_start_out,
  output reg  [CODE_W-1:0] error_code_out,
  output reg               error_available_out
);
  localparam ST_IDLE = 2'b01;
  localparam ST_POLL = 2'b10;

  reg  [15:0]       event_status_reg;
  reg  [15:0]       event_enable_mask_reg;
  reg  [7:0]        service_enable_mask_reg;
  reg               request_service_bit_reg;
  reg  [3:0]        summary_prev_reg;
  reg               power_seen_reg;
  reg  [1:0]        reply_state_reg;
  reg  [1:0]        reply_state_next;
  reg  [15:0]       event_status_next;
  reg               rqs_next;
  wire [7:0]        poll_summary_byte;
  wire              event_summary_bit;
  wire              message_available_bit;
  wire              error_available_bit;
  wire              status_change_summary_bit;
  wire              master_summary_bit;
  wire [3:0]        summary_now;
  wire [3:0]        summary_enabled;
  wire              rqs_rise;
  wire              clear_events;
  wire              read_events;
  wire [15:0]       event_set;
  wire              ctrl_p_seen;
  wire [CODE_W-1:0] queue_head;
  wire              queue_nonempty;

  error_code_queue #(
    .CODE_W (CODE_W)
  ) u_error_queue (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .clear_in     (clear_status_in),
    .push_in      (error_push_in),
    .code_in      (error_code_in),
    .pop_in       (error_pop_in),
    .head_out     (queue_head),
    .nonempty_out (queue_nonempty)
  );

  assign event_summary_bit         = |(event_status_reg & event_enable_mask_reg);
  assign message_available_bit     = out_buffer_busy_in;
  assign error_available_bit       = queue_nonempty;
  assign status_change_summary_bit = change_summary_in;
  assign summary_now = {event_summary_bit, message_available_bit, error_available_bit, status_change_summary_bit};
  assign summary_enabled = summary_now & {service_enable_mask_reg[`SB_ESB_BIT], service_enable_mask_reg[`SB_MAV_BIT],
                                          service_enable_mask_reg[`SB_EAV_BIT], service_enable_mask_reg[`SB_STATUS_CHANGE_SUMMARY_BIT_BIT]};
  assign master_summary_bit = |summary_enabled;
  assign rqs_rise = |(summary_enabled & ~summary_prev_reg);

  // Bit 6 shows the request-service bit on a poll and the master summary on a query
  function [7:0] pack_byte;
    input bit6;
    begin
      pack_byte = {1'b0, bit6, event_summary_bit, message_available_bit,
                   error_available_bit, status_change_summary_bit, 2'b00} & (`SB_USED_MASK | 8'h40);
    end
  endfunction

  assign poll_summary_byte = pack_byte(master_summary_bit);
  assign clear_events = clear_status_in || device_clear_in || reset_cmd_in;
  assign read_events  = reg_read_in && (reg_sel_in == `SEL_EVENT_STATUS);
  assign event_set = {8'h00, power_seen_reg, 1'b0, command_error_in, execution_error_in,
                      device_error_in, query_error_in, 1'b0, op_complete_in} & `ES_USED_MASK;
  assign ctrl_p_seen = serial_mode_in && rx_char_valid_in && (rx_char_in == `CHAR_CTRL_P);

  // Events arriving with a clear or read are kept
  always @* begin
    event_status_next = event_status_reg;
    if (clear_events || read_events) begin
      event_status_next = `RST_WORD;
    end
    event_status_next = event_status_next | event_set;
  end

  always @* begin
    rqs_next = request_service_bit_reg;
    if (serial_poll_in || clear_status_in || !master_summary_bit) begin
      rqs_next = 1'b0;
    end
    if (rqs_rise) begin
      rqs_next = 1'b1;
    end
  end

  always @* begin
    case (reply_state_reg)
      ST_IDLE: reply_state_next = ctrl_p_seen ? ST_POLL : ST_IDLE;
      ST_POLL: reply_state_next = ST_IDLE;
      default: reply_state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      event_status_reg        <= `RST_WORD;
      event_enable_mask_reg   <= `RST_WORD;
      service_enable_mask_reg <= `RST_BYTE;
      request_service_bit_reg <= 1'b0;
      summary_prev_reg        <= 4'h0;
      power_seen_reg          <= 1'b0;
      reply_state_reg         <= ST_IDLE;
      reg_rdata_out           <= 16'h0000;
      reg_rvalid_out          <= 1'b0;
      poll_byte_out           <= `RST_BYTE;
      poll_valid_out          <= 1'b0;
      srq_out                 <= 1'b0;
      srq_string_start_out    <= 1'b0;
      poll_string_start_out   <= 1'b0;
      error_code_out          <= {CODE_W{1'b0}};
      error_available_out     <= 1'b0;
    end else begin
      power_seen_reg          <= power_cycled_in && !power_seen_reg;
      event_status_reg        <= event_status_next;
      request_service_bit_reg <= rqs_next;
      summary_prev_reg        <= summary_enabled;
      reply_state_reg         <= reply_state_next;
      srq_out                 <= rqs_next && !serial_mode_in;
      srq_string_start_out    <= serial_mode_in && rqs_next && !request_service_bit_reg;
      poll_string_start_out   <= ctrl_p_seen;
      error_code_out          <= queue_head;
      error_available_out     <= queue_nonempty;
      poll_valid_out          <= serial_poll_in || (reply_state_reg == ST_POLL);
      if (serial_poll_in || reply_state_reg == ST_POLL) begin
        poll_byte_out <= pack_byte(request_service_bit_reg);
      end
      if (reg_write_in && reg_sel_in == `SEL_SVC_ENABLE) begin
        service_enable_mask_reg <= reg_wdata_in[7:0] & `SB_USED_MASK;
      end
      if (reg_write_in && reg_sel_in == `SEL_EVENT_ENABLE) begin
        event_enable_mask_reg <= reg_wdata_in;
      end
      reg_rvalid_out <= reg_read_in;
      if (reg_read_in) begin
        case (reg_sel_in)
          `SEL_POLL_BYTE:    reg_rdata_out <= {8'h00, poll_summary_byte};
          `SEL_SVC_ENABLE:   reg_rdata_out <= {8'h00, service_enable_mask_reg};
          `SEL_EVENT_STATUS: reg_rdata_out <= event_status_reg;
          `SEL_EVENT_ENABLE: reg_rdata_out <= event_enable_mask_reg;
          default:           reg_rdata_out <= 16'h0000;
        endcase
      end
    end
  end
endmodule // status_byte_service_request

// ===== verif/status_byte_properties.sv
// Port checker of the status and service request block
// Assumes it is bound into status_byte_service_request
`timescale 1ns/100ps
module status_byte_checker (
  input wire        clk_in, rst_in, serial_mode_in, serial_poll_in, clear_status_in, error_push_in,
  input wire        rx_char_valid_in, reg_read_in, reg_rvalid_out, poll_valid_out, srq_out,
  input wire        poll_string_start_out, error_available_out,
  input wire [7:0]  rx_char_in, poll_byte_out,
  input wire [1:0]  reg_sel_in,
  input wire [15:0] reg_rdata_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_poll_answer: assert property (serial_poll_in |=> poll_valid_out)
    else $error("serial poll not answered");
  a_poll_rqs_bit: assert property (serial_poll_in && !serial_mode_in |=> poll_byte_out[6] == $past(srq_out))
    else $error("poll bit 6 differs from request line");
  a_reset_clears: assert property (disable iff (1'b0) rst_in |=> !srq_out && poll_byte_out == 8'h00)
    else $error("outputs not zero after reset");
  a_poll_unused_zero: assert property (poll_valid_out |-> (poll_byte_out & 8'h83) == 8'h00)
    else $error("unused poll bits set");
  a_event_upper_zero: assert property (reg_rvalid_out && $past(reg_read_in) && $past(reg_sel_in) == 2'h2 |->
    (reg_rdata_out & 16'hff42) == 16'h0000)
    else $error("unused event bits set");
  a_read_answer: assert property (reg_read_in |=> reg_rvalid_out)
    else $error("register read not answered");
  a_ctrlp_reply: assert property (serial_mode_in && rx_char_valid_in && rx_char_in == 8'h10 |=>
    poll_string_start_out ##1 poll_valid_out)
    else $error("control-P reply out of order");
  a_srq_serial_off: assert property (serial_mode_in && $past(serial_mode_in) |-> !srq_out)
    else $error("request line driven in serial mode");
  a_clear_errors: assert property (clear_status_in && !error_push_in |-> ##[1:2] !error_available_out)
    else $error("error queue not emptied");
  c_poll_srq: cover property (serial_poll_in && srq_out);
  c_ctrlp: cover property (poll_string_start_out);
  c_read_data: cover property (reg_rvalid_out && reg_rdata_out != 16'h0000);
endmodule // status_byte_checker
bind status_byte_service_request status_byte_checker u_checker (.clk_in, .rst_in, .serial_mode_in,
  .serial_poll_in, .clear_status_in, .error_push_in, .rx_char_valid_in, .reg_read_in, .reg_rvalid_out,
  .poll_valid_out, .srq_out, .poll_string_start_out, .error_available_out, .rx_char_in, .poll_byte_out,
  .reg_sel_in, .reg_rdata_out);

// ===== verif/bus_host_model.sv
// Bus controller and serial host: serial polls and control-P on request
// Assumes one-cycle request pulses on clk_in
`timescale 1ns/100ps
module bus_host_model (
  input  wire       clk_in,
  input  wire       poll_req_in,
  input  wire       ctrlp_req_in,
  input  wire       poll_valid_in,
  input  wire [7:0] poll_byte_in,
  output reg        serial_poll_out = 1'b0,
  output reg        rx_char_valid_out = 1'b0,
  output reg  [7:0] rx_char_out = 8'h00,
  output reg  [7:0] last_byte_out = 8'h00
);
  always @(posedge clk_in) begin
    serial_poll_out   <= poll_req_in;
    rx_char_valid_out <= ctrlp_req_in;
    rx_char_out       <= ctrlp_req_in ? 8'h10 : ~rx_char_out;
    if (poll_valid_in) last_byte_out <= poll_byte_in;
  end
endmodule // bus_host_model

// ===== verif/testbench.sv
// Self-checking bench of the status and service request block
// Assumes the bus host model drives polls and received characters
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench;
  reg         clk_in = 1'b0, rst_in = 1'b1, serial_mode_in = 1'b0, out_buffer_busy_in = 1'b0;
  reg         change_summary_in = 1'b0, reg_write_in = 1'b0, reg_read_in = 1'b0, poll_req = 1'b0, ctrlp_req = 1'b0;
  reg  [10:0] ev = 11'h000;
  reg  [1:0]  reg_sel_in = 2'h0;
  reg  [15:0] reg_wdata_in = 16'h0000, error_code_in = 16'h0000, rd, exp;
  reg  [15:0] codes [0:15];
  wire [15:0] reg_rdata_out, error_code_out;
  wire [7:0]  poll_byte_out, rx_char_in, last_byte;
  wire        reg_rvalid_out, poll_valid_out, srq_out, srq_string_start_out, poll_string_start_out;
  wire        error_available_out, serial_poll_in, rx_char_valid_in;
  integer     n_fail = 0, tests_run = 0, i, k, m;
  always #5 clk_in = ~clk_in;
  status_byte_service_request u_status_byte_service_request (.clk_in, .rst_in, .serial_mode_in, .serial_poll_in,
    .clear_status_in(ev[6]), .device_clear_in(ev[7]), .reset_cmd_in(ev[8]), .power_cycled_in(ev[5]),
    .out_buffer_busy_in, .change_summary_in, .command_error_in(ev[0]), .execution_error_in(ev[1]),
    .device_error_in(ev[2]), .query_error_in(ev[3]), .op_complete_in(ev[4]), .error_code_in,
    .error_push_in(ev[9]), .error_pop_in(ev[10]), .rx_char_valid_in, .rx_char_in, .reg_write_in, .reg_read_in,
    .reg_sel_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .poll_byte_out, .poll_valid_out, .srq_out,
    .srq_string_start_out, .poll_string_start_out, .error_code_out, .error_available_out);
  bus_host_model u_bus_host_model (.clk_in, .poll_req_in(poll_req), .ctrlp_req_in(ctrlp_req),
    .poll_valid_in(poll_valid_out), .poll_byte_in(poll_byte_out), .serial_poll_out(serial_poll_in),
    .rx_char_valid_out(rx_char_valid_in), .rx_char_out(rx_char_in), .last_byte_out(last_byte));
  function [15:0] ev_bits(input [4:0] b);
    ev_bits = {10'h000, b[0], b[1], b[2], b[3], 1'b0, b[4]};
  endfunction
  task final_report; begin
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  end endtask
  task pulse(input [10:0] p); begin
    ev <= p;
    @(posedge clk_in);
    ev <= 11'h000;
    repeat (4) @(posedge clk_in);
  end endtask
  task acc(input w, input [1:0] s, input [15:0] d); begin
    reg_sel_in <= s; reg_wdata_in <= d; reg_write_in <= w; reg_read_in <= !w;
    @(posedge clk_in);
    reg_write_in <= 1'b0; reg_read_in <= 1'b0; k = 0;
    #1;
    while (!w && reg_rvalid_out !== 1'b1 && k < 4) begin @(posedge clk_in); #1; k++; end
    if (k == 4) begin n_fail++; final_report; end
    rd = reg_rdata_out;
    @(posedge clk_in);
  end endtask
  initial begin
    k = $urandom(32'h3715f5ec);
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    for (i = 0; i < 4; i++) begin acc(0, i[1:0], 0); `CHK("reset value", 16'h0000, rd) end
    for (i = 0; i < 12; i++) begin
      exp = $urandom; m = $urandom % 32;
      acc(1, 2'h3, exp); acc(0, 2'h3, 0); `CHK("event mask", exp, rd)
      acc(1, 2'h1, exp); acc(0, 2'h1, 0); `CHK("service mask", exp & 16'h003c, rd)
      acc(1, 2'h2, exp); acc(1, 2'h0, exp); acc(0, 2'h2, 0); `CHK("status write", 16'h0000, rd)
      pulse({6'h00, m[4:0]}); acc(0, 2'h2, 0); `CHK("event status", ev_bits(m[4:0]), rd)
      acc(0, 2'h2, 0); `CHK("event after read", 16'h0000, rd)
    end
    for (i = 6; i < 9; i++) begin pulse(11'h001); pulse(11'h001 << i); acc(0, 2'h2, 0); `CHK("event clear", 16'h0000, rd) end
    pulse(11'h020); acc(0, 2'h2, 0); `CHK("power bit", 16'h0080, rd)
    acc(1, 2'h3, 16'h0020); acc(1, 2'h1, 16'h0020); pulse(11'h001);
    `CHK("request line", 1'b1, srq_out)
    acc(0, 2'h0, 0); `CHK("status byte", 16'h0060, rd)
    poll_req <= 1'b1; @(posedge clk_in); poll_req <= 1'b0; repeat (5) @(posedge clk_in);
    `CHK("poll byte", 8'h60, last_byte)
    `CHK("line after poll", 1'b0, srq_out)
    acc(0, 2'h0, 0); `CHK("summary after poll", 16'h0060, rd)
    acc(1, 2'h1, 16'h0000); acc(0, 2'h0, 0); `CHK("masked summary", 16'h0020, rd)
    acc(1, 2'h1, 16'h0020); out_buffer_busy_in <= 1'b1; change_summary_in <= 1'b1; error_code_in <= 16'h0123;
    pulse(11'h200); acc(0, 2'h0, 0); `CHK("all summaries", 16'h007c, rd)
    pulse(11'h040); acc(0, 2'h0, 0); `CHK("after clear status", 16'h0014, rd)
    for (i = 0; i < 16; i++) begin codes[i] = $urandom; error_code_in <= codes[i]; pulse(11'h200); end
    for (i = 0; i < 15; i++) begin pulse(11'h400); `CHK("error code", codes[i], error_code_out) end
    `CHK("queue empty", 1'b0, error_available_out)
    out_buffer_busy_in <= 1'b0; change_summary_in <= 1'b0; serial_mode_in <= 1'b1;
    acc(1, 2'h1, 16'h0010); pulse(11'h040); out_buffer_busy_in <= 1'b1; m = 0;
    repeat (6) begin @(posedge clk_in); #1; m = m + srq_string_start_out; end
    @(posedge clk_in);
    `CHK("string starts", 32'd1, m)
    `CHK("line in serial mode", 1'b0, srq_out)
    ctrlp_req <= 1'b1; @(posedge clk_in); ctrlp_req <= 1'b0; repeat (6) @(posedge clk_in);
    `CHK("control-P byte", 8'h50, last_byte)
    final_report;
  end
endmodule // testbench
